// ---- hdl/hpsf_status.sv ----
// Status word served to the external host on the parallel host port.
// Assumes all event and strobe inputs are one-cycle pulses on core_clk;
// vbus_above_pin and otg_id_pin are raw pins and are synchronised here.
// Functional notes
// - Status word readable only by external host
// - Status read starts no CPU memory cycle
// - Bit 15 shows VBUS above threshold
// - Bit 14 shows the OTG ID level
// - Bits 12, 10 flag SOF/EOP events
// - Bits 9, 1 flag USB reset events
// - Bit 8 mailbox in, CPU read clears
// - Bits 7, 6 flag resume events
// - Bits 5, 4 message writes, status read clears
// - Bits 3, 2 flag done/endpoint events
// - Bit 0 mailbox out, host read clears
// - Engine events show only when routed to host
// - Message write sets flag and raises interrupt
// - Mailbox write raises interrupt; host read drops
`timescale 1ns/1ps
`default_nettype none
module hpsf_status (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Pins from the OTG front end
  input wire logic vbus_above_pin,
  input wire logic otg_id_pin,
  // Engine interrupt pulses: [0]reset1 [1]done1 [2]done2 [3]resume1
  // [4]resume2 [5]reset2 [6]sof1 [7]sof2
  input wire logic [hpsf_pkg::N_ROUTED-1:0] engine_evt,
  // Routing bits, same order; 1 sends the event to the host port
  input wire logic [hpsf_pkg::N_ROUTED-1:0] route_to_host,
  // Clears from the host side handling of each engine flag
  input wire logic [hpsf_pkg::N_ROUTED-1:0] engine_clr,
  // CPU side strobes
  input wire logic cpu_msg1_wr,
  input wire logic cpu_msg2_wr,
  input wire logic cpu_mbox_wr,
  input wire logic cpu_mbox_rd,
  // Host side strobes
  input wire logic host_mbox_wr,
  input wire logic host_mbox_rd,
  input wire logic host_status_rd,
  // Host port outputs
  output logic [hpsf_pkg::STATUS_W-1:0] status_word,
  output logic host_interrupt_out
);
  localparam int unsigned NR = hpsf_pkg::N_ROUTED;

  logic [1:0] pins_sync;
  logic [NR-1:0] eng_q;
  logic [NR-1:0] eng_d;
  logic msg1_q;
  logic msg2_q;
  logic mbox_in_q;
  logic mbox_out_q;
  logic [hpsf_pkg::STATUS_W-1:0] status_q;
  logic [hpsf_pkg::STATUS_W-1:0] status_d;
  wire [NR-1:0] eng_set;
  wire msg1_d;
  wire msg2_d;
  wire mbox_in_d;
  wire mbox_out_d;

  // Pins cross into the clock domain before any use
  hpsf_sync #(
    .WIDTH(2)
  ) u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .async_in({otg_id_pin, vbus_above_pin}),
    .sync_out(pins_sync)
  );

  // Only routed events are captured; set wins over clear
  assign eng_set = engine_evt & route_to_host;
  assign eng_d = eng_set | (eng_q & ~engine_clr);
  // Message flags: any CPU write sets, a status read clears
  assign msg1_d = cpu_msg1_wr | (msg1_q & ~host_status_rd);
  assign msg2_d = cpu_msg2_wr | (msg2_q & ~host_status_rd);
  assign mbox_in_d = host_mbox_wr | (mbox_in_q & ~cpu_mbox_rd);
  assign mbox_out_d = cpu_mbox_wr | (mbox_out_q & ~host_mbox_rd);

  // Assemble the word; the host reads it straight from flops, no memory cycle
  always_comb
  begin
    status_d = hpsf_pkg::STATUS_RST;
    status_d[hpsf_pkg::BIT_VBUS] = pins_sync[0];
    status_d[hpsf_pkg::BIT_ID] = pins_sync[1];
    status_d[hpsf_pkg::BIT_RSVD13] = hpsf_pkg::RSVD_VAL;
    status_d[hpsf_pkg::BIT_RSVD11] = hpsf_pkg::RSVD_VAL;
    status_d[hpsf_pkg::BIT_SOF2] = eng_q[7];
    status_d[hpsf_pkg::BIT_SOF1] = eng_q[6];
    status_d[hpsf_pkg::BIT_RESET2] = eng_q[5];
    status_d[hpsf_pkg::BIT_MBOX_IN] = mbox_in_q;
    status_d[hpsf_pkg::BIT_RESUME2] = eng_q[4];
    status_d[hpsf_pkg::BIT_RESUME1] = eng_q[3];
    status_d[hpsf_pkg::BIT_MSG2] = msg2_q;
    status_d[hpsf_pkg::BIT_MSG1] = msg1_q;
    status_d[hpsf_pkg::BIT_DONE2] = eng_q[2];
    status_d[hpsf_pkg::BIT_DONE1] = eng_q[1];
    status_d[hpsf_pkg::BIT_RESET1] = eng_q[0];
    status_d[hpsf_pkg::BIT_MBOX_OUT] = mbox_out_q;
  end

  // Sticky flags
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      eng_q <= '0;
      msg1_q <= 1'b0;
      msg2_q <= 1'b0;
      mbox_in_q <= 1'b0;
      mbox_out_q <= 1'b0;
    end
    else
    begin
      eng_q <= eng_d;
      msg1_q <= msg1_d;
      msg2_q <= msg2_d;
      mbox_in_q <= mbox_in_d;
      mbox_out_q <= mbox_out_d;
    end
  end

  // Registered status word; no CPU port exists to reach it
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_q <= hpsf_pkg::STATUS_RST;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  assign status_word = status_q;
  // Interrupt follows any pending routed or message flag
  assign host_interrupt_out = (|eng_q) | msg1_q | msg2_q | mbox_out_q;

  // Assertions
  property p_msg_set;
    @(posedge core_clk) disable iff (!arst_n)
    cpu_msg1_wr |=> host_interrupt_out ##1 status_word[hpsf_pkg::BIT_MSG1];
  endproperty
  a_msg_set: assert property (p_msg_set) else $error("message write not flagged");

  property p_msg_clr;
    @(posedge core_clk) disable iff (!arst_n)
    host_status_rd && !cpu_msg2_wr |=> ##1 !status_word[hpsf_pkg::BIT_MSG2];
  endproperty
  a_msg_clr: assert property (p_msg_clr) else $error("status read did not clear msg2");

  property p_mbox_out;
    @(posedge core_clk) disable iff (!arst_n)
    cpu_mbox_wr |=> host_interrupt_out ##1 status_word[hpsf_pkg::BIT_MBOX_OUT];
  endproperty
  a_mbox_out: assert property (p_mbox_out) else $error("mailbox write lost");

  property p_mbox_drop;
    @(posedge core_clk) disable iff (!arst_n)
    host_mbox_rd && !cpu_mbox_wr |=> ##1 !status_word[hpsf_pkg::BIT_MBOX_OUT];
  endproperty
  a_mbox_drop: assert property (p_mbox_drop) else $error("mailbox out not cleared");

  property p_mbox_in;
    @(posedge core_clk) disable iff (!arst_n)
    host_mbox_wr |=> ##1 status_word[hpsf_pkg::BIT_MBOX_IN];
  endproperty
  a_mbox_in: assert property (p_mbox_in) else $error("mailbox in not set");

  property p_unrouted;
    @(posedge core_clk) disable iff (!arst_n)
    engine_evt[1] && !route_to_host[1] && !eng_q[1] |=> ##1 !status_word[hpsf_pkg::BIT_DONE1];
  endproperty
  a_unrouted: assert property (p_unrouted) else $error("unrouted event shown");

  property p_sof2;
    @(posedge core_clk) disable iff (!arst_n)
    engine_evt[7] && route_to_host[7] |=> host_interrupt_out ##1 status_word[hpsf_pkg::BIT_SOF2];
  endproperty
  a_sof2: assert property (p_sof2) else $error("routed sof2 not flagged");

  property p_rsvd;
    @(posedge core_clk) disable iff (!arst_n)
    !status_word[hpsf_pkg::BIT_RSVD13] && !status_word[hpsf_pkg::BIT_RSVD11];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit nonzero");

  property p_vbus;
    @(posedge core_clk) disable iff (!arst_n)
    vbus_above_pin [*4] |-> status_word[hpsf_pkg::BIT_VBUS];
  endproperty
  a_vbus: assert property (p_vbus) else $error("vbus not reported");

  // VBUS pin low for four cycles, through both sync stages and the status flop, must read back low
  property p_vbus_low;
    @(posedge core_clk) disable iff (!arst_n)
    !vbus_above_pin [*4] |-> !status_word[hpsf_pkg::BIT_VBUS];
  endproperty
  a_vbus_low: assert property (p_vbus_low) else $error("vbus shown above threshold");

  property p_id;
    @(posedge core_clk) disable iff (!arst_n)
    otg_id_pin [*4] |-> status_word[hpsf_pkg::BIT_ID];
  endproperty
  a_id: assert property (p_id) else $error("id high not reported");

  property p_id_low;
    @(posedge core_clk) disable iff (!arst_n)
    !otg_id_pin [*4] |-> !status_word[hpsf_pkg::BIT_ID];
  endproperty
  a_id_low: assert property (p_id_low) else $error("id low not reported");

  // A clear landing with its own event must not lose that event
  property p_set_wins;
    @(posedge core_clk) disable iff (!arst_n)
    engine_evt[0] && route_to_host[0] && engine_clr[0]
      |=> host_interrupt_out ##1 status_word[hpsf_pkg::BIT_RESET1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a same-cycle reset1 event");

  c_msg: cover property (@(posedge core_clk) disable iff (!arst_n) cpu_msg1_wr ##[1:20] host_status_rd);
  c_set_wins: cover property (@(posedge core_clk) disable iff (!arst_n) engine_evt[0] && engine_clr[0]);
  c_mbox: cover property (@(posedge core_clk) disable iff (!arst_n) cpu_mbox_wr ##[1:20] host_mbox_rd);
  c_evt: cover property (@(posedge core_clk) disable iff (!arst_n) |eng_set);
endmodule // hpsf_status
`default_nettype wire

// ---- hdl/hpsf_pkg.sv ----
// Package for the host port status flags block.
// Assumes a single device clock; used by hpsf_status, not by hpsf_sync.
`default_nettype none
package hpsf_pkg;
  localparam int unsigned STATUS_W = 16;
  // Bit positions in the status word
  localparam int unsigned BIT_MBOX_OUT = 0;
  localparam int unsigned BIT_RESET1 = 1;
  localparam int unsigned BIT_DONE1 = 2;
  localparam int unsigned BIT_DONE2 = 3;
  localparam int unsigned BIT_MSG1 = 4;
  localparam int unsigned BIT_MSG2 = 5;
  localparam int unsigned BIT_RESUME1 = 6;
  localparam int unsigned BIT_RESUME2 = 7;
  localparam int unsigned BIT_MBOX_IN = 8;
  localparam int unsigned BIT_RESET2 = 9;
  localparam int unsigned BIT_SOF1 = 10;
  localparam int unsigned BIT_RSVD11 = 11;
  localparam int unsigned BIT_SOF2 = 12;
  localparam int unsigned BIT_RSVD13 = 13;
  localparam int unsigned BIT_ID = 14;
  localparam int unsigned BIT_VBUS = 15;
  // Number of routed engine interrupt sources
  localparam int unsigned N_ROUTED = 8;
  // Reset value of the whole registered status word
  localparam logic [STATUS_W-1:0] STATUS_RST = 16'h0000;
  // Value driven on reserved positions
  localparam logic RSVD_VAL = 1'b0;
endpackage : hpsf_pkg
`default_nettype wire

// ---- hdl/hpsf_sync.sv ----
// Two-stage level synchroniser for asynchronous pin inputs.
// Assumes the input is a slowly moving level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module hpsf_sync #(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // hpsf_sync
`default_nettype wire

// ---- tb/hpsf_host_model.sv ----
// Model of the external host on the parallel host port.
// Assumes bench requests are one-cycle pulses; strobes follow one edge later.
`timescale 1ns/1ps
`default_nettype none
module hpsf_host_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Requests: [0]status read [1]mailbox write [2]mailbox read
  input wire logic [2:0] req,
  // Strobes to the device
  output logic host_status_rd,
  output logic host_mbox_wr,
  output logic host_mbox_rd
);
  // Registered, so each strobe repeats its request one edge later, cycle for cycle
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {host_mbox_rd, host_mbox_wr, host_status_rd} <= 3'h0;
    end
    else
    begin
      {host_mbox_rd, host_mbox_wr, host_status_rd} <= req;
    end
  end
endmodule // hpsf_host_model
`default_nettype wire

// ---- tb/tb_host_port_status_flags.sv ----
// Self-checking bench for the host port status word and host interrupt.
// Assumes the design and host model compile ahead of this file.
`timescale 1ns/1ps
`default_nettype none
module tb_host_port_status_flags;
  logic core_clk, arst_n, vbus, id, look, hs_rd, hm_wr, hm_rd, irq;
  logic [7:0] evt, route, clr, rt;
  logic [3:0] cpu;
  logic [2:0] req;
  logic [15:0] sw, exp_w;
  logic [16:0] q[$];
  int num_errors, n_tests, cyc;
  int unsigned pos [8] = '{1, 2, 3, 6, 7, 9, 10, 12};

  hpsf_host_model hpsf_host_model_inst (.core_clk(core_clk), .arst_n(arst_n), .req(req),
    .host_status_rd(hs_rd), .host_mbox_wr(hm_wr), .host_mbox_rd(hm_rd));
  hpsf_status hpsf_status_inst (.core_clk(core_clk), .arst_n(arst_n), .vbus_above_pin(vbus),
    .otg_id_pin(id), .engine_evt(evt), .route_to_host(route), .engine_clr(clr),
    .cpu_msg1_wr(cpu[0]), .cpu_msg2_wr(cpu[1]), .cpu_mbox_wr(cpu[2]), .cpu_mbox_rd(cpu[3]),
    .host_mbox_wr(hm_wr), .host_mbox_rd(hm_rd), .host_status_rd(hs_rd),
    .status_word(sw), .host_interrupt_out(irq));

  task automatic print_verdict();
    if (num_errors == 0 && n_tests > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [16:0] seen, input logic [16:0] want);
    n_tests++;
    if (seen !== want)
    begin
      num_errors++;
      $display("BAD irq_status exp %h seen %h", want, seen);
    end
  endtask

  // One-cycle pulse, then a settling gap long enough for both latencies
  task automatic step(input logic [7:0] e, input logic [7:0] c, input logic [3:0] p, input logic [2:0] h);
    @(posedge core_clk);
    evt <= e;
    clr <= c;
    cpu <= p;
    req <= h;
    @(posedge core_clk);
    evt <= 8'h00;
    clr <= 8'h00;
    cpu <= 4'h0;
    req <= 3'h0;
    repeat (5) @(posedge core_clk);
    q.push_back({|(exp_w & 16'h16FF), exp_w});
    look <= 1'b1;
    @(posedge core_clk);
    look <= 1'b0;
  endtask

  // Outputs are read at the falling edge, well clear of updates
  always @(negedge core_clk)
  begin
    if (look)
    begin
      check({irq, sw}, q.pop_front());
    end
  end

  // Guards against a hang
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial
  begin
    {arst_n, vbus, id, look, evt, route, clr, cpu, req} = '0;
    exp_w = 16'h0000;
    void'($urandom(32'hC4F5));
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    step(8'h00, 8'h00, 4'h0, 3'h0);
    // Random routing; reset1 and sof2 forced to the host, done1 kept on the CPU side
    rt = 8'($urandom()) & 8'hFD | 8'h81;
    route <= rt;
    for (int i = 0; i < 8; i++)
    begin
      exp_w[pos[i]] = rt[i];
      step(8'h01 << i, 8'h00, 4'h0, 3'h0);
      exp_w[pos[i]] = 1'b0;
      step(8'h00, 8'h01 << i, 4'h0, 3'h0);
    end
    // Event and clear in the same cycle: the event must win
    exp_w[1] = 1'b1;
    step(8'h01, 8'h01, 4'h0, 3'h0);
    exp_w[1] = 1'b0;
    step(8'h00, 8'h01, 4'h0, 3'h0);
    exp_w[4] = 1'b1;
    step(8'h00, 8'h00, 4'h1, 3'h0);
    exp_w[5] = 1'b1;
    step(8'h00, 8'h00, 4'h2, 3'h0);
    exp_w[5:4] = 2'h0;
    step(8'h00, 8'h00, 4'h0, 3'h1);
    exp_w[0] = 1'b1;
    step(8'h00, 8'h00, 4'h4, 3'h0);
    exp_w[0] = 1'b0;
    step(8'h00, 8'h00, 4'h0, 3'h4);
    exp_w[8] = 1'b1;
    step(8'h00, 8'h00, 4'h0, 3'h2);
    exp_w[8] = 1'b0;
    step(8'h00, 8'h00, 4'h8, 3'h0);
    // A reset in mid-run must drop a pending message flag
    exp_w[4] = 1'b1;
    step(8'h00, 8'h00, 4'h1, 3'h0);
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    exp_w[4] = 1'b0;
    step(8'h00, 8'h00, 4'h0, 3'h0);
    // Every pin combination, read only after the settle time
    for (int k = 0; k < 4; k++)
    begin
      @(posedge core_clk);
      vbus <= k[0];
      id <= k[1];
      repeat (250) @(posedge core_clk);
      exp_w[15] = k[0];
      exp_w[14] = k[1];
      step(8'h00, 8'h00, 4'h0, 3'h0);
    end
    print_verdict();
  end
endmodule // tb_host_port_status_flags
`default_nettype wire
